//--- dv/mw_host_model.sv
module mw_host_model (
  // Core clock
  input  wire logic clk,
  // Link to the device
  output logic      cs,
  output logic      sk,
  output logic      di,
  input  wire logic do_line
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs = 1'b0;
    sk = 1'b0;
    di = 1'b0;
  end

  // SK stays still outside frames; the device only sees edges inside CS.
  task automatic start();
    @(negedge clk);
    cs <= 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // DI settles half an SK period before each rise and holds through it.
  task automatic send(input int n, input logic [31:0] bits);
    for (int i = n - 1; i >= 0; i--) begin
      sk <= 1'b0;
      di <= bits[i];
      repeat (4) @(negedge clk);
      sk <= 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask

  task automatic recv(input int n, output logic [31:0] bits);
    bits = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      sk <= 1'b0;
      repeat (4) @(negedge clk);
      bits = {bits[30:0], do_line};
      sk <= 1'b1;
      repeat (4) @(negedge clk);
    end
  endtask

  // One microsecond low is well past the minimum gap between programs.
  task automatic finish();
    sk <= 1'b0;
    repeat (4) @(negedge clk);
    cs <= 1'b0;
    di <= ~di;
    repeat (10) @(negedge clk);
  endtask
endmodule

//--- dv/mw_supervisor_props.sv
module mw_supervisor_props #(
  parameter int WDOG_CYCLES = 200,
  parameter int POR_CYCLES  = 50,
  parameter int PROG_CYCLES = 40
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Serial link
  input wire logic CS,
  input wire logic SK,
  input wire logic DI,
  input wire logic DO_OUT,
  input wire logic DO_OE,
  // Straps and supply
  input wire logic WORD_WIDTH_SELECT,
  input wire logic SUPPLY_GOOD,
  // Reset pins
  input wire logic RST_HI_IN,
  input wire logic RST_HI_OUT,
  input wire logic RST_HI_OE,
  input wire logic RST_LO_N_IN,
  input wire logic RST_LO_N_OUT,
  input wire logic RST_LO_N_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  logic [3:0]  sk_age_r;
  logic        sk_q_r;
  logic        cs_q_r;
  logic [31:0] idle_r;
  logic [31:0] held_r;

  // Age of the last SK rise, saturating so it never wraps back to recent.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sk_q_r   <= 1'b0;
      sk_age_r <= 4'hF;
    end else begin
      sk_q_r   <= SK;
      sk_age_r <= (SK && !sk_q_r) ? 4'h0 :
                  (sk_age_r == 4'hF) ? sk_age_r : sk_age_r + 4'h1;
    end
  end

  // Idle time seen by the watchdog, and length of the current reset pulse.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cs_q_r <= 1'b0;
      idle_r <= 32'h0000_0000;
      held_r <= 32'h0000_0000;
    end else begin
      cs_q_r <= CS;
      idle_r <= (RST_HI_OE || CS != cs_q_r || RST_HI_IN || !RST_LO_N_IN ||
                 !SUPPLY_GOOD) ? 32'h0000_0000 : idle_r + 32'h0000_0001;
      held_r <= (RST_HI_OE && SUPPLY_GOOD) ? held_r + 32'h0000_0001 :
                32'h0000_0000;
    end
  end

  chk_rst_pair: assert property (
    RST_HI_OE == RST_LO_N_OE && (!RST_HI_OE || RST_HI_OUT && !RST_LO_N_OUT))
    else $error("reset outputs disagree");
  chk_supply_drop: assert property (
    $fell(SUPPLY_GOOD) |-> ##[1:8] RST_HI_OE)
    else $error("supply drop did not assert reset");
  chk_por_len: assert property (
    $fell(RST_HI_OE) |-> held_r >= POR_CYCLES - 4)
    else $error("reset pulse too short");
  chk_wdog_bite: assert property (
    idle_r < WDOG_CYCLES + 12)
    else $error("watchdog did not expire");
  chk_do_float: assert property (
    !CS [*8] |-> !DO_OE)
    else $error("data out driven while deselected");
  chk_dummy_zero: assert property (
    $rose(DO_OE) && sk_age_r < 4'hA |-> !DO_OUT)
    else $error("read did not start with a zero");
  chk_read_step: assert property (
    $fell(DO_OUT) && DO_OE && $past(DO_OE) |-> sk_age_r < 4'hA)
    else $error("read data changed without a clock rise");
  chk_pin_edge: assert property (
    ($rose(RST_HI_IN) || $fell(RST_LO_N_IN)) && !RST_HI_OE &&
    !$past(RST_HI_OE) |-> ##[1:10] RST_HI_OE)
    else $error("reset pin edge ignored");
endmodule

bind mw_supervisor mw_supervisor_props #(
  .WDOG_CYCLES(WDOG_CYCLES),
  .POR_CYCLES (POR_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)
) i_props (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CS(CS), .SK(SK), .DI(DI),
  .DO_OUT(DO_OUT), .DO_OE(DO_OE), .WORD_WIDTH_SELECT(WORD_WIDTH_SELECT),
  .SUPPLY_GOOD(SUPPLY_GOOD), .RST_HI_IN(RST_HI_IN),
  .RST_HI_OUT(RST_HI_OUT), .RST_HI_OE(RST_HI_OE),
  .RST_LO_N_IN(RST_LO_N_IN), .RST_LO_N_OUT(RST_LO_N_OUT),
  .RST_LO_N_OE(RST_LO_N_OE)
);

//--- dv/mw_supervisor_tb.sv
`include "mw_supervisor_map.svh"
`define CHECK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module mw_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WDOG = 200;
  localparam int POR  = 50;

  logic core_clk = 1'b0;
  logic arst_n, wide, supply, rst_hi_ext, rst_lo_drv, float_r;
  logic cs, sk, di, do_out, do_oe, do_line;
  logic rst_hi_in, rst_hi_out, rst_hi_oe;
  logic rst_lo_n_in, rst_lo_n_out, rst_lo_n_oe;
  int   errors = 0;
  int   total_checks = 0;

  always #50 core_clk = ~core_clk;
  // A released data line shows a changing level, never a stale one.
  always @(posedge core_clk) float_r <= (float_r === 1'b1) ? 1'b0 : 1'b1;
  assign do_line = do_oe ? do_out : float_r;
  // Pull-down on the high pin, pull-up on the low pin.
  assign rst_hi_in   = (rst_hi_oe & rst_hi_out) | rst_hi_ext;
  assign rst_lo_n_in = ~((rst_lo_n_oe & ~rst_lo_n_out) | rst_lo_drv);

  mw_supervisor #(
    .WDOG_CYCLES(WDOG),
    .POR_CYCLES (POR),
    .PROG_CYCLES(40)
  ) i_dut (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .CS(cs), .SK(sk), .DI(di),
    .DO_OUT(do_out), .DO_OE(do_oe), .WORD_WIDTH_SELECT(wide),
    .SUPPLY_GOOD(supply), .RST_HI_IN(rst_hi_in), .RST_HI_OUT(rst_hi_out),
    .RST_HI_OE(rst_hi_oe), .RST_LO_N_IN(rst_lo_n_in),
    .RST_LO_N_OUT(rst_lo_n_out), .RST_LO_N_OE(rst_lo_n_oe)
  );
  mw_host_model i_host (
    .clk(core_clk), .cs(cs), .sk(sk), .di(di), .do_line(do_line)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic instr(input logic [1:0] op, input logic [8:0] a,
                       input logic [15:0] d, input bit has_data);
    i_host.start();
    if (wide) begin
      i_host.send(11, {21'h0, 1'b1, op, a[7:0]});
      if (has_data) i_host.send(16, {16'h0, d});
    end else begin
      i_host.send(12, {20'h0, 1'b1, op, a});
      if (has_data) i_host.send(8, {24'h0, d[7:0]});
    end
  endtask

  task automatic prog(input logic [1:0] op, input logic [8:0] a,
                      input logic [15:0] d, input bit has_data);
    instr(op, a, d, has_data);
    i_host.finish();
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    logic [31:0] got;
    instr(`OPC_READ, a, 16'h0000, 1'b0);
    i_host.recv(wide ? 17 : 9, got);
    i_host.finish();
    `CHECK(got, {16'h0000, exp})
  endtask

  task automatic wait_ready();
    logic done = 1'b0;
    for (int n = 0; n < 100 && !done; n++) begin
      i_host.start();
      `CHECK(do_oe, 1'b1)
      if (n == 0) `CHECK(do_out, 1'b0)
      done = do_out;
      i_host.finish();
    end
    `CHECK(done, 1'b1)
  endtask

  task automatic no_status();
    i_host.start();
    `CHECK(do_oe, 1'b0)
    i_host.finish();
  endtask

  task automatic wait_release();
    for (int n = 0; n < 300 && rst_hi_oe !== 1'b0; n++) @(negedge core_clk);
    `CHECK(rst_lo_n_oe, 1'b0)
    // The echo of our own drive must leave the pin synchronisers first,
    // or a new pin edge right after release is never seen as an edge.
    repeat (8) @(negedge core_clk);
  endtask

  task automatic t_power_up();
    int n = 0;
    `CHECK(rst_hi_oe, 1'b1)
    while (rst_hi_oe === 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    `CHECK(n >= POR, 1'b1)
  endtask

  task automatic t_memory();
    prog(`OPC_WRITE, 9'h005, 16'h0011, 1'b1);
    no_status();
    prog(`OPC_SPECIAL, {`SEL_ENABLE, 7'h00}, 16'h0000, 1'b0);
    prog(`OPC_SPECIAL, {`SEL_ERASE_ALL, 7'h00}, 16'h0000, 1'b0);
    wait_ready();
    rd(9'h000, 16'h00FF);
    rd(9'h1FF, 16'h00FF);
    prog(`OPC_WRITE, 9'h005, 16'h00A5, 1'b1);
    prog(`OPC_WRITE, 9'h006, 16'h005A, 1'b1);
    wait_ready();
    rd(9'h005, 16'h00A5);
    rd(9'h006, 16'h005A);
    prog(`OPC_ERASE, 9'h005, 16'h0000, 1'b0);
    wait_ready();
    rd(9'h005, 16'h00FF);
    rd(9'h006, 16'h005A);
    prog(`OPC_SPECIAL, {`SEL_WRITE_ALL, 7'h00}, 16'h003C, 1'b1);
    wait_ready();
    rd(9'h000, 16'h003C);
    rd(9'h1FF, 16'h003C);
  endtask

  task automatic t_wide_and_lock();
    wide = 1'b1;
    repeat (8) @(negedge core_clk);
    rd(9'h002, 16'h3C3C);
    prog(`OPC_WRITE, 9'h003, 16'h8001, 1'b1);
    wait_ready();
    rd(9'h003, 16'h8001);
    wide = 1'b0;
    repeat (8) @(negedge core_clk);
    rd(9'h006, 16'h0080);
    prog(`OPC_SPECIAL, {`SEL_DISABLE, 7'h00}, 16'h0000, 1'b0);
    prog(`OPC_WRITE, 9'h007, 16'h0000, 1'b1);
    no_status();
    rd(9'h007, 16'h0001);
  endtask

  task automatic t_supervisor();
    repeat (150) @(negedge core_clk);
    i_host.start();
    i_host.finish();
    repeat (150) @(negedge core_clk);
    `CHECK(rst_hi_oe, 1'b0)
    repeat (80) @(negedge core_clk);
    `CHECK(rst_lo_n_oe, 1'b1)
    wait_release();
    rst_hi_ext = 1'b1;
    repeat (10) @(negedge core_clk);
    `CHECK(rst_hi_oe, 1'b1)
    repeat (140) @(negedge core_clk);
    rst_hi_ext = 1'b0;
    repeat (150) @(negedge core_clk);
    `CHECK(rst_hi_oe, 1'b0)
    rst_lo_drv = 1'b1;
    repeat (10) @(negedge core_clk);
    `CHECK(rst_lo_n_oe, 1'b1)
    rst_lo_drv = 1'b0;
    wait_release();
    supply = 1'b0;
    repeat (10) @(negedge core_clk);
    `CHECK(rst_hi_oe, 1'b1)
    supply = 1'b1;
    wait_release();
    repeat (170) @(negedge core_clk);
    `CHECK(rst_hi_oe, 1'b0)
  endtask

  initial begin
    arst_n = 1'b0;
    wide = 1'b0;
    supply = 1'b1;
    rst_hi_ext = 1'b0;
    rst_lo_drv = 1'b0;
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    t_power_up();
    t_memory();
    t_wide_and_lock();
    t_supervisor();
    report_and_stop();
  end

  initial begin
    #3000000;
    errors++;
    report_and_stop();
  end
endmodule

//--- hdl/mw_supervisor.sv
// What this block does
// - Accept 11-bit instructions in by-16 mode, 12-bit in by-8 mode.
// - Start bit, two opcode bits, then nine (x8) or eight (x16) bits.
// - DI bits are captured on each rising SK edge.
// - DO floats except during read data or ready/busy status.
// - With CS high after a program start, DO low busy, high ready.
// - Read drives a dummy zero, then data most significant bit first.
// - Read data bits on DO advance on rising SK edges.
// - CS fall after write launches erase-then-write of that location.
// - CS fall after erase clears the location to all ones.
// - Writes disabled after power-up until the enable instruction.
// - Write enable persists until power loss or disable instruction.
// - Program instructions ignored while disabled; reads always work.
// - CS fall after erase-all clears every location, self-timed.
// - CS fall after write-all writes data everywhere, self-timed.
// - Watchdog expiry asserts both reset outputs.
// - Any CS transition restarts the watchdog.
// - Watchdog held clear while supply low and power-up reset period.
// - Reset input holds watchdog clear until later of release or period.
// - Outputs asserted until supply good plus 200 ms; reassert on drop.
// - Rising RESET or falling RESET# edge starts a full reset time-out.

`include "mw_supervisor_map.svh"

////////////////////////////////////////////////////////////////////////////
module mw_cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module mw_supervisor
  import mw_supervisor_pkg::*;
#(
  parameter int WDOG_CYCLES = `WDOG_PERIOD_MS * `CLK_KHZ,
  parameter int POR_CYCLES  = `POWER_UP_RESET_MS * `CLK_KHZ,
  parameter int PROG_CYCLES = `PROG_CYCLE_US * (`CLK_KHZ / 1000)
) (
  // Clock and reset
  input  wire logic CORE_CLK,
  input  wire logic ARST_N,
  // Serial link
  input  wire logic CS,
  input  wire logic SK,
  input  wire logic DI,
  output logic      DO_OUT,
  output logic      DO_OE,
  // Straps and supply
  input  wire logic WORD_WIDTH_SELECT,
  input  wire logic SUPPLY_GOOD,
  // Reset pins, open drain
  input  wire logic RST_HI_IN,
  output logic      RST_HI_OUT,
  output logic      RST_HI_OE,
  input  wire logic RST_LO_N_IN,
  output logic      RST_LO_N_OUT,
  output logic      RST_LO_N_OE
);
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_HDR  = 3'h1,
    PH_DATA = 3'h3,
    PH_DONE = 3'h7,
    PH_READ = 3'h2
  } phase_type;

  typedef enum logic [1:0] {
    EX_IDLE = 2'h0,
    EX_WALK = 2'h1,
    EX_WAIT = 2'h3
  } exec_type;

  localparam int NPIN = $bits(pins_type);

  // Header value of the finished instruction, with opcode on top.
  function automatic logic [1:0] opc_of(input logic [10:0] v,
                                        input logic wide);
    return wide ? v[9:8] : v[10:9];
  endfunction

  function automatic logic [8:0] addr_of(input logic [10:0] v,
                                         input logic wide);
    return wide ? {1'b0, v[7:0]} : v[8:0];
  endfunction

  function automatic logic [1:0] sel_of(input logic [8:0] a,
                                        input logic wide);
    return wide ? a[7:6] : a[8:7];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree.
  logic [NPIN-1:0] raw;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  pins_type        pin_r;
  pins_type        pin_prev_r;

  assign raw = {CS, SK, DI, WORD_WIDTH_SELECT, SUPPLY_GOOD,
                RST_HI_IN, RST_LO_N_IN};

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        s1_r[i]  <= 1'b0;
        s2_r[i]  <= 1'b0;
        s3_r[i]  <= 1'b0;
        pin_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= raw[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          pin_r[i] <= s3_r[i];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_prev_r <= '0;
    end else begin
      pin_prev_r <= pin_r;
    end
  end

  logic sk_rise;
  logic cs_rise;
  logic cs_fall;
  logic wide;

  assign sk_rise = pin_r.cs && pin_r.sk && !pin_prev_r.sk;
  assign cs_rise = pin_r.cs && !pin_prev_r.cs;
  assign cs_fall = !pin_r.cs && pin_prev_r.cs;
  assign wide    = pin_r.wide;

  //////////////////////////////////////////////////////////////////////////
  // Instruction decoder.
  logic [7:0]  mem_bytes [`MEM_BYTES];
  phase_type   phase_r;
  logic [4:0]  cnt_r;
  logic [10:0] hdr_r;
  logic [15:0] data_r;
  logic [15:0] rd_sh_r;
  logic        rd_bit_r;
  logic        wen_r;
  logic        armed_r;
  cmd_type     cmd_r;
  logic [10:0] hv;
  logic [1:0]  opc;
  logic [8:0]  addr;
  logic [4:0]  hdr_last;
  logic [4:0]  data_last;

  assign hv        = {hdr_r[9:0], pin_r.di};
  assign opc       = opc_of(hv, wide);
  assign addr      = addr_of(hv, wide);
  // Opcode plus address bits, counted after the start bit.
  assign hdr_last  = wide ? 5'(`OPC_BITS + `ADDR_BITS_X16 - 1)
                          : 5'(`OPC_BITS + `ADDR_BITS_X8 - 1);
  assign data_last = wide ? 5'(`DATA_BITS_X16 - 1)
                          : 5'(`DATA_BITS_X8 - 1);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phase_r  <= PH_IDLE;
      cnt_r    <= '0;
      hdr_r    <= '0;
      data_r   <= '0;
      rd_sh_r  <= '0;
      rd_bit_r <= 1'b0;
      armed_r  <= 1'b0;
      cmd_r    <= '0;
    end else if (!pin_r.cs) begin
      // Deselect aborts any partial instruction.
      phase_r <= PH_IDLE;
      armed_r <= 1'b0;
    end else if (sk_rise) begin
      unique case (phase_r)
        PH_IDLE: begin
          if (pin_r.di) begin
            phase_r <= PH_HDR;
            cnt_r   <= '0;
          end
        end
        PH_HDR: begin
          hdr_r <= hv;
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == hdr_last) begin
            cnt_r      <= '0;
            cmd_r.addr <= addr;
            cmd_r.wide <= wide;
            phase_r    <= PH_DONE;
            unique case (opc)
              `OPC_READ: begin
                phase_r  <= PH_READ;
                rd_bit_r <= 1'b0;
                rd_sh_r  <= wide ? {mem_bytes[{addr[7:0], 1'b0}][7:0],
                                    mem_bytes[{addr[7:0], 1'b1}][7:0]}
                                 : {mem_bytes[addr][7:0], 8'h00};
              end
              `OPC_WRITE: begin
                cmd_r.op <= OP_WRITE;
                phase_r  <= PH_DATA;
              end
              `OPC_ERASE: begin
                cmd_r.op <= OP_ERASE;
                armed_r  <= wen_r;
              end
              default: begin
                unique case (sel_of(addr, wide))
                  `SEL_WRITE_ALL: begin
                    cmd_r.op <= OP_WRITE_EVERY_LOCATION_INSTR;
                    phase_r  <= PH_DATA;
                  end
                  `SEL_ERASE_ALL: begin
                    cmd_r.op <= OP_ERASE_EVERY_LOCATION_INSTR;
                    armed_r  <= wen_r;
                  end
                  default: begin
                  end
                endcase
              end
            endcase
          end
        end
        PH_DATA: begin
          data_r <= {data_r[14:0], pin_r.di};
          cnt_r  <= cnt_r + 5'h01;
          if (cnt_r == data_last) begin
            cmd_r.data <= {data_r[14:0], pin_r.di};
            armed_r    <= wen_r;
            phase_r    <= PH_DONE;
          end
        end
        PH_READ: begin
          rd_bit_r <= rd_sh_r[15];
          rd_sh_r  <= {rd_sh_r[14:0], 1'b0};
        end
        PH_DONE: begin
        end
        default: begin
          phase_r <= PH_IDLE;
        end
      endcase
    end
  end

  // Enable latch sits beside the decoder; power loss or the disable instruction clears it.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wen_r <= 1'b0;
    end else if (!pin_r.supply_good) begin
      wen_r <= 1'b0;
    end else if (sk_rise && phase_r == PH_HDR && cnt_r == hdr_last &&
                 opc == `OPC_SPECIAL) begin
      if (sel_of(addr, wide) == `SEL_ENABLE) begin
        wen_r <= 1'b1;
      end else if (sel_of(addr, wide) == `SEL_DISABLE) begin
        wen_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Launch: a finished program instruction waits here until the queue
  // takes it; while the queue is full the next launch overwrites it.
  logic    pend_v_r;
  cmd_type pend_r;
  logic    q_in_ready;
  logic    q_out_valid;
  logic    q_out_ready;
  cmd_type q_out;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_v_r <= 1'b0;
      pend_r   <= '0;
    end else if (cs_fall && armed_r) begin
      pend_v_r <= 1'b1;
      pend_r   <= cmd_r;
    end else if (q_in_ready) begin
      pend_v_r <= 1'b0;
    end
  end

  mw_cmd_fifo #(
    .WIDTH ($bits(cmd_type)),
    .DEPTH (`CMD_FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .in_valid  (pend_v_r),
    .in_ready  (q_in_ready),
    .in_data   (pend_r),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // Self-timed executor: walks the byte range, then waits out the
  // program time. Single words take one or two bytes, bulk ops all.
  exec_type    ex_r;
  cmd_type     ex_cmd_r;
  logic [8:0]  idx_r;
  logic [8:0]  last_r;
  logic [23:0] prog_cnt_r;
  logic [7:0]  wr_byte;

  assign q_out_ready = (ex_r == EX_IDLE);

  always_comb begin
    wr_byte = `ERASED_BYTE;
    if (ex_cmd_r.op == OP_WRITE || ex_cmd_r.op == OP_WRITE_EVERY_LOCATION_INSTR) begin
      // Erase and write fold into one overwrite.
      if (ex_cmd_r.wide && !idx_r[0]) begin
        wr_byte = ex_cmd_r.data[15:8];
      end else begin
        wr_byte = ex_cmd_r.data[7:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (ex_r == EX_WALK) begin
      mem_bytes[idx_r] <= wr_byte;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ex_r       <= EX_IDLE;
      ex_cmd_r   <= '0;
      idx_r      <= '0;
      last_r     <= '0;
      prog_cnt_r <= '0;
    end else begin
      unique case (ex_r)
        EX_IDLE: begin
          if (q_out_valid) begin
            ex_cmd_r <= q_out;
            ex_r     <= EX_WALK;
            if (q_out.op == OP_ERASE_EVERY_LOCATION_INSTR || q_out.op == OP_WRITE_EVERY_LOCATION_INSTR) begin
              idx_r  <= '0;
              last_r <= 9'(`MEM_BYTES - 1);
            end else if (q_out.wide) begin
              idx_r  <= {q_out.addr[7:0], 1'b0};
              last_r <= {q_out.addr[7:0], 1'b1};
            end else begin
              idx_r  <= q_out.addr;
              last_r <= q_out.addr;
            end
          end
        end
        EX_WALK: begin
          idx_r <= idx_r + 9'h001;
          if (idx_r == last_r) begin
            ex_r       <= EX_WAIT;
            prog_cnt_r <= '0;
          end
        end
        EX_WAIT: begin
          prog_cnt_r <= prog_cnt_r + 24'h000001;
          if (prog_cnt_r == 24'(PROG_CYCLES - 1)) begin
            ex_r <= EX_IDLE;
          end
        end
        default: begin
          ex_r <= EX_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // DO: read data, or ready/busy once a program op has been launched.
  logic busy;
  logic status_r;

  assign busy = pend_v_r || q_out_valid || (ex_r != EX_IDLE);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status_r <= 1'b0;
    end else if (cs_fall && armed_r) begin
      status_r <= 1'b1;
    end else if (sk_rise && phase_r == PH_IDLE && pin_r.di) begin
      status_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DO_OUT <= 1'b0;
      DO_OE  <= 1'b0;
    end else begin
      DO_OE  <= pin_r.cs && (phase_r == PH_READ || status_r);
      DO_OUT <= (phase_r == PH_READ) ? rd_bit_r : !busy;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset controller and watchdog.
  logic        rst_act_r;
  logic [23:0] por_cnt_r;
  logic [23:0] wd_cnt_r;
  logic        ext_edge;
  logic        ext_held;
  logic        wd_expire;

  // Our own drive would echo back on the pins, so inputs are only
  // heard while the outputs are released.
  assign ext_edge  = !rst_act_r &&
                     ((pin_r.rst_hi && !pin_prev_r.rst_hi) ||
                      (!pin_r.rst_lo_n && pin_prev_r.rst_lo_n));
  assign ext_held  = !rst_act_r && (pin_r.rst_hi || !pin_r.rst_lo_n);
  assign wd_expire = (wd_cnt_r == 24'(WDOG_CYCLES - 1));

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_act_r <= 1'b1;
      por_cnt_r <= '0;
    end else if (!pin_r.supply_good) begin
      rst_act_r <= 1'b1;
      por_cnt_r <= '0;
    end else if (ext_edge || wd_expire) begin
      rst_act_r <= 1'b1;
      por_cnt_r <= '0;
    end else if (rst_act_r) begin
      por_cnt_r <= por_cnt_r + 24'h000001;
      if (por_cnt_r == 24'(POR_CYCLES - 1)) begin
        rst_act_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wd_cnt_r <= '0;
    end else if (rst_act_r || ext_held) begin
      wd_cnt_r <= '0;
    end else if (cs_rise || cs_fall) begin
      wd_cnt_r <= '0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RST_HI_OUT   <= 1'b1;
      RST_HI_OE    <= 1'b1;
      RST_LO_N_OUT <= 1'b0;
      RST_LO_N_OE  <= 1'b1;
    end else begin
      RST_HI_OUT   <= 1'b1;
      RST_HI_OE    <= rst_act_r;
      RST_LO_N_OUT <= 1'b0;
      RST_LO_N_OE  <= rst_act_r;
    end
  end
endmodule

//--- hdl/mw_supervisor_map.svh
`ifndef MW_SUPERVISOR_MAP_SVH
`define MW_SUPERVISOR_MAP_SVH

// Core clock rate.
`define CLK_KHZ            10000

// Supervisor timing, in the units printed.
`define WDOG_PERIOD_MS     1600
`define POWER_UP_RESET_MS  200
`define HOST_CS_LOW_NS     250
// Self-timed program cycle; a plain default.
`define PROG_CYCLE_US      5000

// Instruction layout.
`define OPC_BITS           2
`define ADDR_BITS_X8       9
`define ADDR_BITS_X16      8
`define DATA_BITS_X8       8
`define DATA_BITS_X16      16
`define MEM_BYTES          512

// Opcodes and special selectors in the top two address bits.
`define OPC_SPECIAL        2'h0
`define OPC_WRITE          2'h1
`define OPC_READ           2'h2
`define OPC_ERASE          2'h3
`define SEL_DISABLE        2'h0
`define SEL_WRITE_ALL      2'h1
`define SEL_ERASE_ALL      2'h2
`define SEL_ENABLE         2'h3

`define ERASED_BYTE        8'hFF
`define CMD_FIFO_DEPTH     32

`endif

//--- hdl/mw_supervisor_pkg.sv
package mw_supervisor_pkg;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_ERASE = 2'h1,
    OP_ERASE_EVERY_LOCATION_INSTR  = 2'h2,
    OP_WRITE_EVERY_LOCATION_INSTR  = 2'h3
  } op_type;

  typedef struct packed {
    op_type      op;
    logic        wide;
    logic [8:0]  addr;
    logic [15:0] data;
  } cmd_type;

  // Synchronised pin levels.
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
    logic wide;
    logic supply_good;
    logic rst_hi;
    logic rst_lo_n;
  } pins_type;

endpackage
